// file: hdl/pcr_regs.svh
// offsets, field positions, reset values and timing counts of the phy control register
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

`define PCR_ADDR_W 5
`define PCR_DATA_W 16
`define PCR_CONTROL_ADDR 5'h00
`define PCR_CONTROL_RESET 16'h3100

`define PCR_BIT_SOFT_RESET 15
`define PCR_BIT_LOOPBACK 14
`define PCR_BIT_SPEED 13
`define PCR_BIT_ANEG_EN 12
`define PCR_BIT_POWER_DOWN 11
`define PCR_BIT_ISOLATE 10
`define PCR_BIT_ANEG_RESTART 9
`define PCR_BIT_DUPLEX 8
`define PCR_BIT_COL_TEST 7
`define PCR_RSVD_HI 6
`define PCR_RSVD_LO 0
`define PCR_RSVD_VALUE 7'h00

`define PCR_CLK_MHZ 125
`define PCR_SOFT_RESET_NS 80
`define PCR_SOFT_RESET_CYCLES ((`PCR_SOFT_RESET_NS * `PCR_CLK_MHZ + 999) / 1000)
`define PCR_SR_CNT_W 8

`endif

// file: hdl/pcr_pkg.sv
// types shared by the phy control register files
`default_nettype none
`include "pcr_regs.svh"

package pcr_pkg;
  typedef logic [`PCR_ADDR_W-1:0] pcr_addr_t;
  typedef logic [`PCR_DATA_W-1:0] pcr_word_t;
  typedef logic [`PCR_SR_CNT_W-1:0] pcr_sr_cnt_t;
  typedef enum logic [1:0] {
    PCR_RUN,
    PCR_SOFT_RESET
  } pcr_state_t;
endpackage

`default_nettype wire

// file: hdl/pcr_collision_test.sv
// collision indication while collision test mode is on
`timescale 1ns/10ps
`default_nettype none

module pcr_collision_test (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic collision_test,
  input wire logic tx_en,
  output logic collision
);
  logic collision_next;

  always_comb begin
    collision_next = collision_test & tx_en;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      collision <= 1'b0;
    end else begin
      collision <= collision_next;
    end
  end
endmodule

`default_nettype wire

// file: hdl/pcr_phy_control.sv
// phy control register at management address zero with its control outputs
// How it works
// - register at address zero, 16 bits, read and write, resets to 0x3100
// - reset values give speed 100, autoneg on, full duplex, normal operation
// - writing bit 7 enters collision test, clearing leaves it, resets to zero
// - collision asserted while transmitting in collision test, dropped when transmit stops
// - bits 6 to 0 reserved, written as zero, read back as zero
// - undefined addresses reserved: writes ignored, reads return zero
`timescale 1ns/10ps
`default_nettype none

`include "pcr_regs.svh"

module pcr_phy_control #(
  parameter int SOFT_RESET_CYCLES = `PCR_SOFT_RESET_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire pcr_pkg::pcr_addr_t mgmt_reg_addr,
  input wire logic mgmt_wr_en,
  input wire pcr_pkg::pcr_word_t mgmt_wdata,
  input wire logic mgmt_rd_en,
  output pcr_pkg::pcr_word_t mgmt_rdata,
  output logic mgmt_rdata_valid,
  input wire logic tx_en,
  input wire logic autoneg_restart_done,
  output logic phy_soft_reset,
  output logic loopback_enable,
  output logic speed_select,
  output logic autoneg_enable,
  output logic power_down,
  output logic isolate,
  output logic autoneg_restart,
  output logic duplex_full,
  output logic collision_test,
  output logic collision
);
  import pcr_pkg::*;

  localparam pcr_sr_cnt_t SR_LAST = pcr_sr_cnt_t'(SOFT_RESET_CYCLES - 1);

  pcr_state_t state_reg;
  pcr_state_t state_next;
  pcr_sr_cnt_t sr_cnt_reg;
  pcr_sr_cnt_t sr_cnt_next;
  logic soft_rst_reg;
  logic soft_rst_next;
  logic loopback_reg;
  logic loopback_next;
  logic speed_reg;
  logic speed_next;
  logic aneg_en_reg;
  logic aneg_en_next;
  logic power_down_reg;
  logic power_down_next;
  logic isolate_reg;
  logic isolate_next;
  logic aneg_restart_reg;
  logic aneg_restart_next;
  logic duplex_reg;
  logic duplex_next;
  logic col_test_reg;
  logic col_test_next;
  pcr_word_t rdata_reg;
  pcr_word_t rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic hit_ctrl;
  logic ctrl_wr;
  logic in_reset;
  pcr_word_t ctrl_view;
  pcr_word_t reset_word;

  assign reset_word = `PCR_CONTROL_RESET;

  // address decode on the absolute register number
  always_comb begin
    hit_ctrl = (mgmt_reg_addr == `PCR_CONTROL_ADDR);
    in_reset = soft_rst_reg;
    ctrl_wr = mgmt_wr_en & hit_ctrl & ~in_reset;
  end

  // soft reset sequencing
  always_comb begin
    state_next = state_reg;
    sr_cnt_next = sr_cnt_reg;
    unique case (state_reg)
      PCR_RUN: begin
        if (ctrl_wr && mgmt_wdata[`PCR_BIT_SOFT_RESET]) begin
          state_next = PCR_SOFT_RESET;
          sr_cnt_next = '0;
        end
      end
      PCR_SOFT_RESET: begin
        if (sr_cnt_reg >= SR_LAST) begin
          state_next = PCR_RUN;
        end else begin
          sr_cnt_next = sr_cnt_reg + pcr_sr_cnt_t'(1);
        end
      end
      default: begin
        state_next = PCR_RUN;
      end
    endcase
    // registered copy so the soft reset output comes from a flop
    soft_rst_next = (state_next == PCR_SOFT_RESET);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= PCR_RUN;
      sr_cnt_reg <= '0;
      soft_rst_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sr_cnt_reg <= sr_cnt_next;
      soft_rst_reg <= soft_rst_next;
    end
  end

  // control field next values
  always_comb begin
    loopback_next = loopback_reg;
    speed_next = speed_reg;
    aneg_en_next = aneg_en_reg;
    power_down_next = power_down_reg;
    isolate_next = isolate_reg;
    aneg_restart_next = aneg_restart_reg;
    duplex_next = duplex_reg;
    col_test_next = col_test_reg;
    if (in_reset || (ctrl_wr && mgmt_wdata[`PCR_BIT_SOFT_RESET])) begin
      // defaults held for the whole soft reset
      loopback_next = reset_word[`PCR_BIT_LOOPBACK];
      speed_next = reset_word[`PCR_BIT_SPEED];
      aneg_en_next = reset_word[`PCR_BIT_ANEG_EN];
      power_down_next = reset_word[`PCR_BIT_POWER_DOWN];
      isolate_next = reset_word[`PCR_BIT_ISOLATE];
      aneg_restart_next = reset_word[`PCR_BIT_ANEG_RESTART];
      duplex_next = reset_word[`PCR_BIT_DUPLEX];
      col_test_next = reset_word[`PCR_BIT_COL_TEST];
    end else begin
      if (autoneg_restart_done) begin
        aneg_restart_next = 1'b0;
      end
      if (ctrl_wr) begin
        loopback_next = mgmt_wdata[`PCR_BIT_LOOPBACK];
        speed_next = mgmt_wdata[`PCR_BIT_SPEED];
        aneg_en_next = mgmt_wdata[`PCR_BIT_ANEG_EN];
        power_down_next = mgmt_wdata[`PCR_BIT_POWER_DOWN];
        isolate_next = mgmt_wdata[`PCR_BIT_ISOLATE];
        duplex_next = mgmt_wdata[`PCR_BIT_DUPLEX];
        col_test_next = mgmt_wdata[`PCR_BIT_COL_TEST];
        // writing zero never cancels a restart; a new request beats done
        if (mgmt_wdata[`PCR_BIT_ANEG_RESTART]) begin
          aneg_restart_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      loopback_reg <= 1'b0;
      speed_reg <= 1'b1;
      aneg_en_reg <= 1'b1;
      power_down_reg <= 1'b0;
      isolate_reg <= 1'b0;
      aneg_restart_reg <= 1'b0;
      duplex_reg <= 1'b1;
      col_test_reg <= 1'b0;
    end else begin
      loopback_reg <= loopback_next;
      speed_reg <= speed_next;
      aneg_en_reg <= aneg_en_next;
      power_down_reg <= power_down_next;
      isolate_reg <= isolate_next;
      aneg_restart_reg <= aneg_restart_next;
      duplex_reg <= duplex_next;
      col_test_reg <= col_test_next;
    end
  end

  // read path, reserved bits always zero
  always_comb begin
    ctrl_view = '0;
    ctrl_view[`PCR_BIT_SOFT_RESET] = in_reset;
    ctrl_view[`PCR_BIT_LOOPBACK] = loopback_reg;
    ctrl_view[`PCR_BIT_SPEED] = speed_reg;
    ctrl_view[`PCR_BIT_ANEG_EN] = aneg_en_reg;
    ctrl_view[`PCR_BIT_POWER_DOWN] = power_down_reg;
    ctrl_view[`PCR_BIT_ISOLATE] = isolate_reg;
    ctrl_view[`PCR_BIT_ANEG_RESTART] = aneg_restart_reg;
    ctrl_view[`PCR_BIT_DUPLEX] = duplex_reg;
    ctrl_view[`PCR_BIT_COL_TEST] = col_test_reg;
    ctrl_view[`PCR_RSVD_HI:`PCR_RSVD_LO] = `PCR_RSVD_VALUE;
    rvalid_next = mgmt_rd_en;
    rdata_next = '0;
    if (mgmt_rd_en && hit_ctrl) begin
      rdata_next = ctrl_view;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  pcr_collision_test u_col_test (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .collision_test(col_test_reg),
    .tx_en(tx_en),
    .collision(collision)
  );

  // outputs straight from flops
  assign mgmt_rdata = rdata_reg;
  assign mgmt_rdata_valid = rvalid_reg;
  assign phy_soft_reset = soft_rst_reg;
  assign loopback_enable = loopback_reg;
  assign speed_select = speed_reg;
  assign autoneg_enable = aneg_en_reg;
  assign power_down = power_down_reg;
  assign isolate = isolate_reg;
  assign autoneg_restart = aneg_restart_reg;
  assign duplex_full = duplex_reg;
  assign collision_test = col_test_reg;
endmodule

`default_nettype wire

// file: dv/pcr_mgmt_master.sv
// management master model driving the register strobes
`timescale 1ns/10ps
`default_nettype none
module pcr_mgmt_master (
  input wire logic clk_sys,
  output pcr_pkg::pcr_addr_t mgmt_reg_addr,
  output logic mgmt_wr_en,
  output pcr_pkg::pcr_word_t mgmt_wdata,
  output logic mgmt_rd_en,
  input wire pcr_pkg::pcr_word_t mgmt_rdata,
  input wire logic mgmt_rdata_valid
);
  import pcr_pkg::*;
  int gap = 0;
  initial begin
    mgmt_reg_addr = 5'h1f;
    mgmt_wr_en = 1'b0;
    mgmt_wdata = 16'hffff;
    mgmt_rd_en = 1'b0;
  end
  task automatic xfer(input logic wr, input pcr_addr_t a, input pcr_word_t d,
                      output pcr_word_t q);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    mgmt_reg_addr <= a;
    mgmt_wdata <= {d[15:7], 7'h00};
    mgmt_wr_en <= wr;
    mgmt_rd_en <= !wr;
    @(posedge clk_sys);
    mgmt_wr_en <= 1'b0;
    mgmt_rd_en <= 1'b0;
    mgmt_reg_addr <= ~a;
    mgmt_wdata <= ~d;
    @(posedge clk_sys);
    q = (mgmt_rdata_valid === 1'b1) ? mgmt_rdata : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

// file: dv/pcr_phy_control_asserts.sv
// port checker for the phy control register
`timescale 1ns/10ps
`default_nettype none
module pcr_phy_control_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire pcr_pkg::pcr_addr_t mgmt_reg_addr,
  input wire logic mgmt_wr_en,
  input wire pcr_pkg::pcr_word_t mgmt_wdata,
  input wire logic mgmt_rd_en,
  input wire pcr_pkg::pcr_word_t mgmt_rdata,
  input wire logic mgmt_rdata_valid,
  input wire logic tx_en,
  input wire logic phy_soft_reset,
  input wire logic speed_select,
  input wire logic autoneg_enable,
  input wire logic duplex_full,
  input wire logic collision_test,
  input wire logic collision
);
  import pcr_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic wr0 = mgmt_wr_en && mgmt_reg_addr == 5'h00 && !phy_soft_reset;
  chk_rd_answer: assert property (
    mgmt_rd_en |=> mgmt_rdata_valid) else $error("read not answered");
  chk_rsvd_zero: assert property (
    mgmt_rdata_valid |-> mgmt_rdata[6:0] == 7'h00) else $error("reserved bits set");
  chk_hole_zero: assert property (
    mgmt_rd_en && mgmt_reg_addr != 5'h00 |=> mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_col_rise: assert property (
    collision_test && tx_en |=> collision) else $error("collision missing");
  chk_col_drop: assert property (
    !tx_en || !collision_test |=> !collision) else $error("collision stuck");
  chk_reset_defaults: assert property (
    $rose(rst_b) |-> speed_select && autoneg_enable && duplex_full && !collision_test
      && !phy_soft_reset) else $error("bad reset defaults");
  chk_test_write: assert property (
    wr0 && !mgmt_wdata[15] |=> collision_test == $past(mgmt_wdata[7]))
    else $error("collision test bit not written");
  chk_soft_load: assert property (
    wr0 && mgmt_wdata[15] |=> phy_soft_reset && speed_select && !collision_test)
    else $error("soft reset not loaded");
  cover property (collision);
  cover property (phy_soft_reset);
  cover property (mgmt_rdata_valid && mgmt_rdata == 16'h3100);
endmodule
bind pcr_phy_control pcr_phy_control_asserts chk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .mgmt_reg_addr(mgmt_reg_addr),
  .mgmt_wr_en(mgmt_wr_en),
  .mgmt_wdata(mgmt_wdata),
  .mgmt_rd_en(mgmt_rd_en),
  .mgmt_rdata(mgmt_rdata),
  .mgmt_rdata_valid(mgmt_rdata_valid),
  .tx_en(tx_en),
  .phy_soft_reset(phy_soft_reset),
  .speed_select(speed_select),
  .autoneg_enable(autoneg_enable),
  .duplex_full(duplex_full),
  .collision_test(collision_test),
  .collision(collision)
);
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the phy control register
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pcr_pkg::*;
  localparam int SR = 8;
  logic clk_sys, rst_b, tx_en, autoneg_restart_done, mgmt_wr_en, mgmt_rd_en, mgmt_rdata_valid;
  pcr_addr_t mgmt_reg_addr;
  pcr_word_t mgmt_wdata, mgmt_rdata, q;
  logic phy_soft_reset, loopback_enable, speed_select, autoneg_enable, power_down, isolate;
  logic autoneg_restart, duplex_full, collision_test, collision;
  int error_cnt = 0;
  int check_count = 0;
  wire pcr_word_t outs = {7'h00, phy_soft_reset, loopback_enable, speed_select,
    autoneg_enable, power_down, isolate, autoneg_restart, duplex_full, collision_test};
  pcr_phy_control #(.SOFT_RESET_CYCLES(SR)) dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .mgmt_reg_addr(mgmt_reg_addr),
    .mgmt_wr_en(mgmt_wr_en),
    .mgmt_wdata(mgmt_wdata),
    .mgmt_rd_en(mgmt_rd_en),
    .mgmt_rdata(mgmt_rdata),
    .mgmt_rdata_valid(mgmt_rdata_valid),
    .tx_en(tx_en),
    .autoneg_restart_done(autoneg_restart_done),
    .phy_soft_reset(phy_soft_reset),
    .loopback_enable(loopback_enable),
    .speed_select(speed_select),
    .autoneg_enable(autoneg_enable),
    .power_down(power_down),
    .isolate(isolate),
    .autoneg_restart(autoneg_restart),
    .duplex_full(duplex_full),
    .collision_test(collision_test),
    .collision(collision)
  );
  pcr_mgmt_master mac (
    .clk_sys(clk_sys),
    .mgmt_reg_addr(mgmt_reg_addr),
    .mgmt_wr_en(mgmt_wr_en),
    .mgmt_wdata(mgmt_wdata),
    .mgmt_rd_en(mgmt_rd_en),
    .mgmt_rdata(mgmt_rdata),
    .mgmt_rdata_valid(mgmt_rdata_valid)
  );
  task automatic cmp(input pcr_word_t g, input pcr_word_t e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input pcr_addr_t a, input pcr_word_t d);
    mac.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input pcr_addr_t a);
    mac.xfer(1'b0, a, 16'h0000, q);
  endtask
  task automatic t_reset;
    rd(5'h00);
    cmp(q, 16'h3100);
    cmp(outs, 16'h0062);
  endtask
  task automatic t_fields;
    pcr_word_t tbl [3] = '{16'h0180, 16'h5c80, 16'h207f};
    foreach (tbl[i]) begin
      wr(5'h00, tbl[i]);
      cmp(outs, {7'h00, tbl[i][15:7]});
      rd(5'h00);
      cmp(q, {tbl[i][15:7], 7'h00});
    end
  endtask
  task automatic t_restart;
    wr(5'h00, 16'h3300);
    wr(5'h00, 16'h3100);
    cmp(outs, 16'h0066);
    autoneg_restart_done <= 1'b1;
    @(posedge clk_sys);
    autoneg_restart_done <= 1'b0;
    @(posedge clk_sys);
    cmp(outs, 16'h0062);
  endtask
  task automatic t_coll;
    wr(5'h00, 16'h3180);
    tx_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cmp({15'h0, collision}, 16'h0001);
    tx_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp({15'h0, collision}, 16'h0000);
    wr(5'h00, 16'h3100);
    tx_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cmp({15'h0, collision}, 16'h0000);
    tx_en <= 1'b0;
  endtask
  task automatic t_soft;
    wr(5'h00, 16'h4080);
    wr(5'h00, 16'h8000);
    rd(5'h00);
    cmp(q, 16'hb100);
    wr(5'h00, 16'h0080);
    cmp(outs, 16'h0162);
    repeat (SR) @(posedge clk_sys);
    rd(5'h00);
    cmp(q, 16'h3100);
  endtask
  task automatic t_hole;
    wr(5'h01, 16'hffff);
    wr(5'h1f, 16'hffff);
    cmp(outs, 16'h0062);
    rd(5'h1f);
    cmp(q, 16'h0000);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    rst_b = 1'b0;
    tx_en = 1'b0;
    autoneg_restart_done = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_fields();
    t_restart();
    t_coll();
    t_soft();
    mac.gap = 3;
    t_hole();
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
